// [option_byte_config_decoder.sv]
/*
 option_byte_config_decoder: holds the two option bytes, serves the
 programming port, and latches decoded hardware settings after reset.
 assumes programming-port pins come from outside the clock domain and
 halt / watchdog inputs come from logic on clk.
*/
`timescale 1ns/10ps
module option_byte_config_decoder #(
    parameter bit         ROM_CODED = 1'b0,
    parameter logic [7:0] ROM_BYTE0 = option_cfg_pkg::ROM_BYTE0_DEF,
    parameter logic [7:0] ROM_BYTE1 = option_cfg_pkg::ROM_BYTE1_DEF
) (
    input  wire logic                                  clk,
    input  wire logic                                  rst_b,
    input  wire logic                                  prog_mode,
    input  wire logic                                  prog_wr,
    input  wire logic                                  prog_rd,
    input  wire logic                                  prog_sel,
    input  wire logic [7:0]                            prog_wdata,
    output logic      [7:0]                            prog_rdata,
    output logic                                       prog_rvalid,
    output logic                                       mem_wipe,
    input  wire logic                                  halt_req,
    input  wire logic                                  watchdog_sw_on,
    output logic                                       readout_protect,
    output logic                                       clock_glitch_filter,
    output logic [option_cfg_pkg::OSC_N-1:0]           osc_source_sel,
    output logic                                       supply_drop_detector,
    output logic [option_cfg_pkg::THR_N-1:0]           supply_drop_threshold_sel,
    output logic [option_cfg_pkg::IRQ_LINES-1:0]       irq_vec0_lines,
    output logic [option_cfg_pkg::IRQ_LINES-1:0]       irq_vec1_lines,
    output logic                                       watchdog_enable,
    output logic                                       halt_wdg_reset,
    output logic                                       halt_enter
);
    logic [11:0] pin_lvl;
    logic        mode_f;
    logic        sel_f;
    logic [7:0]  wdata_f;
    logic        wr_f;
    logic        rd_f;
    logic        wr_d_reg;
    logic        rd_d_reg;
    logic        wr_edge;
    logic        rd_edge;
    logic [7:0]  nv0_reg;
    logic [7:0]  nv1_reg;
    logic [7:0]  nv0_next;
    logic [7:0]  nv1_next;
    logic [7:0]  eff0;
    logic [7:0]  eff1;
    logic        wr_ok;
    logic        wipe_hit;
    logic [7:0]  rdata_next;
    logic        loading;
    option_cfg_pkg::load_state_e state_reg;

    logic                                  prot_reg;
    logic                                  cf_reg;
    logic [option_cfg_pkg::OSC_N-1:0]      osc_reg;
    logic [option_cfg_pkg::OSC_N-1:0]      osc_next;
    logic                                  sdd_reg;
    logic [option_cfg_pkg::THR_N-1:0]      thr_reg;
    logic [option_cfg_pkg::THR_N-1:0]      thr_next;
    logic                                  map_reg;
    logic                                  watchdog_halt_reset_reg;
    logic                                  wdg_soft_reg;
    logic                                  sw_en_reg;
    logic                                  wdg_en_reg;
    logic [7:0]                            rdata_reg;
    logic                                  rvalid_reg;
    logic                                  wipe_reg;
    logic                                  hreset_reg;
    logic                                  henter_reg;
    logic [option_cfg_pkg::IRQ_LINES-1:0]  v0_reg;
    logic [option_cfg_pkg::IRQ_LINES-1:0]  v1_reg;

    // select and data ride the same synchroniser as the strobes;
    // the tool must settle them a cycle before the strobe rises
    pin_sync3 #(
        .WIDTH (12)
    ) u_pin_sync (
        .clk       (clk),
        .rst_b     (rst_b),
        .pin_in    ({prog_mode, prog_wr, prog_rd, prog_sel, prog_wdata}),
        .level_out (pin_lvl)
    );

    assign mode_f  = pin_lvl[11];
    assign wr_f    = pin_lvl[10];
    assign rd_f    = pin_lvl[9];
    assign sel_f   = pin_lvl[8];
    assign wdata_f = pin_lvl[7:0];
    assign wr_edge = wr_f & ~wr_d_reg;
    assign rd_edge = rd_f & ~rd_d_reg;

    // no memory-map port exists; only the programming port reaches the bytes
    assign wr_ok    = wr_edge & mode_f & ~ROM_CODED;
    // a 1->0 change of the protect bit wipes instead of storing
    assign wipe_hit = wr_ok & (sel_f == option_cfg_pkg::SEL_BYTE0)
                    & nv0_reg[option_cfg_pkg::B0_READOUT_PROTECT_POS]
                    & ~wdata_f[option_cfg_pkg::B0_READOUT_PROTECT_POS];

    // reserved bits stored as the tool writes them; tool supplies ones
    assign nv0_next = wipe_hit ? option_cfg_pkg::WIPED_BYTE :
                      (wr_ok & (sel_f == option_cfg_pkg::SEL_BYTE0)) ? wdata_f : nv0_reg;
    assign nv1_next = wipe_hit ? option_cfg_pkg::WIPED_BYTE :
                      (wr_ok & (sel_f == option_cfg_pkg::SEL_BYTE1)) ? wdata_f : nv1_reg;

    // factory-coded parts ignore the cells entirely
    assign eff0 = ROM_CODED ? ROM_BYTE0 : nv0_reg;
    assign eff1 = ROM_CODED ? ROM_BYTE1 : nv1_reg;

    assign rdata_next = (sel_f == option_cfg_pkg::SEL_BYTE0) ? eff0 : eff1;
    assign loading    = (state_reg == option_cfg_pkg::ST_LOAD);

    always_comb begin
        osc_next = '0;
        unique casez (eff1[option_cfg_pkg::B1_OSC_LSB +: 3])
            3'b111:  osc_next[option_cfg_pkg::OSC_EXT_CK] = 1'b1;
            3'b110:  osc_next[option_cfg_pkg::OSC_INT_RC] = 1'b1;
            3'b10?:  osc_next[option_cfg_pkg::OSC_EXT_RC] = 1'b1;
            3'b011:  osc_next[option_cfg_pkg::OSC_LP]     = 1'b1;
            3'b010:  osc_next[option_cfg_pkg::OSC_MP]     = 1'b1;
            3'b001:  osc_next[option_cfg_pkg::OSC_MS]     = 1'b1;
            3'b000:  osc_next[option_cfg_pkg::OSC_HS]     = 1'b1;
        endcase
    end

    always_comb begin
        thr_next = '0;
        unique case (eff1[option_cfg_pkg::B1_SUPPLY_LSB +: 2])
            2'b11: thr_next = '0;
            2'b10: thr_next[option_cfg_pkg::THR_HIGH] = 1'b1;
            2'b01: thr_next[option_cfg_pkg::THR_MED]  = 1'b1;
            2'b00: thr_next[option_cfg_pkg::THR_LOW]  = 1'b1;
        endcase
    end

    // port lines: [21:16] port C, [15:8] port B, [7:0] port A
    function automatic logic [option_cfg_pkg::IRQ_LINES-1:0] vec_lines(input logic first,
                                                                       input logic map_bit);
        logic [option_cfg_pkg::IRQ_LINES-1:0] m;
        m = first ? {{option_cfg_pkg::PC_N{~map_bit}}, 8'h00, 8'hFF}
                  : {{option_cfg_pkg::PC_N{map_bit}}, 8'hFF, 8'h00};
        return m;
    endfunction

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nv0_reg <= option_cfg_pkg::ERASED_BYTE;
            nv1_reg <= option_cfg_pkg::ERASED_BYTE;
        end else begin
            nv0_reg <= nv0_next;
            nv1_reg <= nv1_next;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= option_cfg_pkg::ST_LOAD;
        end else begin
            state_reg <= option_cfg_pkg::ST_RUN;
        end
    end

    // decoded settings only move in the load cycle after reset; later
    // programming never reaches them, as reset reloads the erased bytes before the load
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prot_reg     <= 1'b1;
            cf_reg       <= 1'b0;
            osc_reg      <= '0;
            sdd_reg      <= 1'b0;
            thr_reg      <= '0;
            map_reg      <= 1'b1;
            watchdog_halt_reset_reg <= 1'b1;
            wdg_soft_reg <= 1'b1;
            v0_reg       <= '0;
            v1_reg       <= '0;
        end else if (loading) begin
            prot_reg     <= eff0[option_cfg_pkg::B0_READOUT_PROTECT_POS];
            cf_reg       <= ~eff1[option_cfg_pkg::B1_CLK_FILT_POS];
            osc_reg      <= osc_next;
            sdd_reg      <= ~&eff1[option_cfg_pkg::B1_SUPPLY_LSB +: 2];
            thr_reg      <= thr_next;
            map_reg      <= eff0[option_cfg_pkg::B0_IRQ_MAP_POS];
            watchdog_halt_reset_reg <= eff1[option_cfg_pkg::B1_WATCHDOG_HALT_RESET_POS];
            wdg_soft_reg <= eff1[option_cfg_pkg::B1_WDG_SOFT_POS];
            v0_reg       <= vec_lines(1'b1, eff0[option_cfg_pkg::B0_IRQ_MAP_POS]);
            v1_reg       <= vec_lines(1'b0, eff0[option_cfg_pkg::B0_IRQ_MAP_POS]);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_d_reg   <= 1'b0;
            rd_d_reg   <= 1'b0;
            rdata_reg  <= '0;
            rvalid_reg <= 1'b0;
            wipe_reg   <= 1'b0;
        end else begin
            wr_d_reg   <= wr_f;
            rd_d_reg   <= rd_f;
            rvalid_reg <= rd_edge & mode_f;
            wipe_reg   <= wipe_hit;
            if (rd_edge && mode_f) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // software enable is sticky until reset, as a watchdog start should be
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_en_reg  <= 1'b0;
            wdg_en_reg <= 1'b0;
            hreset_reg <= 1'b0;
            henter_reg <= 1'b0;
        end else begin
            sw_en_reg  <= sw_en_reg | watchdog_sw_on;
            wdg_en_reg <= ~loading & (~wdg_soft_reg | sw_en_reg);
            hreset_reg <= halt_req & wdg_en_reg & watchdog_halt_reset_reg;
            henter_reg <= halt_req & ~(wdg_en_reg & watchdog_halt_reset_reg);
        end
    end

    assign prog_rdata                = rdata_reg;
    assign prog_rvalid               = rvalid_reg;
    assign mem_wipe                  = wipe_reg;
    assign readout_protect           = prot_reg;
    assign clock_glitch_filter       = cf_reg;
    assign osc_source_sel            = osc_reg;
    assign supply_drop_detector      = sdd_reg;
    assign supply_drop_threshold_sel = thr_reg;
    assign irq_vec0_lines            = v0_reg;
    assign irq_vec1_lines            = v1_reg;
    assign watchdog_enable           = wdg_en_reg;
    assign halt_wdg_reset            = hreset_reg;
    assign halt_enter                = henter_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_wipe_zeroes: assert property (wipe_hit |=> (nv0_reg == 8'h00) && (nv1_reg == 8'h00)
                                    ##0 mem_wipe) else $error("wipe did not clear");
    a_noprog_hold: assert property (!mode_f |=> $stable(nv0_reg) && $stable(nv1_reg))
        else $error("bytes changed outside programming mode");
    a_read_mode: assert property (prog_rvalid |-> $past(mode_f))
        else $error("read answered outside programming mode");
    a_rom_fixed: assert property (ROM_CODED && $rose(prog_rvalid) |-> prog_rdata == ROM_BYTE0
                                  || prog_rdata == ROM_BYTE1) else $error("rom value");
    a_cfg_stable: assert property ((state_reg == option_cfg_pkg::ST_RUN) |=> $stable(osc_reg)
                                   && $stable(prot_reg) && $stable(v0_reg))
        else $error("settings moved in run");
    a_irq_cover: assert property ((state_reg == option_cfg_pkg::ST_RUN) |->
                                  ((v0_reg | v1_reg) == '1) && ((v0_reg & v1_reg) == '0)
                                  && (v0_reg[21] == ~map_reg))
        else $error("irq split wrong");
    a_osc_onehot: assert property ((state_reg == option_cfg_pkg::ST_RUN) |-> $onehot(osc_reg))
        else $error("osc select not one-hot");
    a_thr_off: assert property ((state_reg == option_cfg_pkg::ST_RUN) |->
                                (sdd_reg == (thr_reg != '0)))
        else $error("detector enable and threshold disagree");
    a_halt_reset: assert property (halt_req && wdg_en_reg && watchdog_halt_reset_reg |=>
                                   halt_wdg_reset && !halt_enter)
        else $error("halt reset missing");
    a_hw_wdg: assert property ((state_reg == option_cfg_pkg::ST_RUN) && !wdg_soft_reg
                               ##1 1'b1 |-> watchdog_enable)
        else $error("hardware watchdog off");

    c_write0: cover property (wr_ok && sel_f == option_cfg_pkg::SEL_BYTE0);
    c_wipe:   cover property (mem_wipe);
    c_read:   cover property (prog_rvalid);
    c_hreset: cover property (halt_wdg_reset);
endmodule

// [option_cfg_pkg.sv]
/*
 option_cfg_pkg: field positions, erased and default values, load states
 for the option byte decoder. assumes one clock domain, active-low reset.
*/
package option_cfg_pkg;

    localparam int unsigned BYTE_W = 8;

    // byte 0 fields
    localparam int unsigned B0_READOUT_PROTECT_POS = 0;
    localparam int unsigned B0_IRQ_MAP_POS         = 1;
    localparam int unsigned B0_RSVD_LSB            = 2;

    // byte 1 fields
    localparam int unsigned B1_WDG_SOFT_POS  = 0;
    localparam int unsigned B1_WATCHDOG_HALT_RESET_POS  = 1;
    localparam int unsigned B1_SUPPLY_LSB    = 2;
    localparam int unsigned B1_OSC_LSB       = 4;
    localparam int unsigned B1_CLK_FILT_POS  = 7;

    localparam logic [7:0] ERASED_BYTE   = 8'hFF;
    localparam logic [7:0] WIPED_BYTE    = 8'h00;
    localparam logic [7:0] ROM_BYTE0_DEF = 8'hFE;
    localparam logic [7:0] ROM_BYTE1_DEF = 8'hEF;

    // option byte select on the programming port
    localparam logic SEL_BYTE0 = 1'b0;
    localparam logic SEL_BYTE1 = 1'b1;

    // oscillator one-hot positions
    localparam int unsigned OSC_HS     = 0;
    localparam int unsigned OSC_MS     = 1;
    localparam int unsigned OSC_MP     = 2;
    localparam int unsigned OSC_LP     = 3;
    localparam int unsigned OSC_EXT_RC = 4;
    localparam int unsigned OSC_INT_RC = 5;
    localparam int unsigned OSC_EXT_CK = 6;
    localparam int unsigned OSC_N      = 7;

    // supply-drop threshold one-hot positions
    localparam int unsigned THR_LOW  = 0;
    localparam int unsigned THR_MED  = 1;
    localparam int unsigned THR_HIGH = 2;
    localparam int unsigned THR_N    = 3;

    localparam int unsigned PA_N = 8;
    localparam int unsigned PB_N = 8;
    localparam int unsigned PC_N = 6;
    localparam int unsigned IRQ_LINES = PA_N + PB_N + PC_N;

    localparam int unsigned SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b10
    } load_state_e;

endpackage

// [pin_sync3.sv]
/*
 pin_sync3: three-flop synchroniser with agreement filter for pin inputs.
 assumes the inputs are asynchronous levels held for several clocks.
*/
`timescale 1ns/10ps
module pin_sync3 #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;

    // a change only counts once stages two and three agree
    assign level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
    assign level_out  = level_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            level_reg <= '0;
        end else begin
            s1_reg    <= pin_in;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            level_reg <= level_next;
        end
    end
endmodule

// [prog_tool_model.sv]
/*
 prog_tool_model: programming tool on the option byte port.
 assumes clk is the device clock; tasks are called from the bench.
*/
`timescale 1ns/10ps
module prog_tool_model (
    input  wire logic       clk,
    input  wire logic       rvalid,
    input  wire logic [7:0] rdata,
    output logic            prog_mode,
    output logic            prog_wr,
    output logic            prog_rd,
    output logic            prog_sel,
    output logic [7:0]      prog_wdata
);
    initial begin
        prog_mode = 1'b0;
        prog_wr = 1'b0;
        prog_rd = 1'b0;
        prog_sel = 1'b0;
        prog_wdata = 8'h00;
    end

    task automatic set_mode(input logic m);
        @(posedge clk);
        #1;
        prog_mode = m;
        repeat (6) @(posedge clk);
    endtask

    // strobe held six cycles, low five: covers the sync latency
    task automatic wr(input logic sel, input logic [7:0] d);
        @(posedge clk);
        #1;
        prog_sel = sel;
        prog_wdata = (sel == option_cfg_pkg::SEL_BYTE0) ? (d | 8'hfc) : d;
        // data settles a cycle ahead of the strobe, so sync skew cannot split them
        @(posedge clk);
        #1;
        prog_wr = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        prog_wr = 1'b0;
        prog_wdata = ~prog_wdata;
        prog_sel = ~prog_sel;
        repeat (5) @(posedge clk);
    endtask

    task automatic rd(input logic sel, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk);
        #1;
        prog_sel = sel;
        @(posedge clk);
        #1;
        prog_rd = 1'b1;
        for (int n = 0; n < 12 && !ok; n++) begin
            @(posedge clk);
            #1;
            if (rvalid === 1'b1) begin
                ok = 1'b1;
                d = rdata;
            end
        end
        repeat (2) @(posedge clk);
        #1;
        prog_rd = 1'b0;
        prog_sel = ~prog_sel;
        repeat (5) @(posedge clk);
    endtask
endmodule

// [option_byte_config_decoder_tb.sv]
/*
 option_byte_config_decoder_tb: eight factory-coded instances plus one
 programmable instance (index 8). assumes the design's own assertions run.
*/
`timescale 1ns/10ps
module option_byte_config_decoder_tb;
    localparam int N = 9;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        halt_req = 1'b0;
    logic        watchdog_sw_on = 1'b0;
    logic        p_mode, p_wr, p_rd, p_sel;
    logic [7:0]  p_wdata;
    logic [7:0]  rdata_a [N];
    logic        rvalid_a [N], wipe_a [N], rp_a [N], cgf_a [N], det_a [N];
    logic        we_a [N], hwr_a [N], hen_a [N];
    logic [6:0]  osc_a [N];
    logic [2:0]  thr_a [N];
    logic [21:0] v0_a [N], v1_a [N];
    int          wipe_cnt [N];
    int          num_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;

    always #2.5 clk = ~clk;

    function automatic logic [7:0] byte0_of(input int i);
        return (i == 8) ? 8'hff : (8'hfc | i[1:0]);
    endfunction
    function automatic logic [7:0] byte1_of(input int i);
        return (i == 8) ? 8'hff : {~i[0], i[2:0], i[1:0], i[2], i[0] ^ i[1]};
    endfunction

    for (genvar g = 0; g < N; g++) begin : dev_g
        option_byte_config_decoder #(
            .ROM_CODED (g < 8),
            .ROM_BYTE0 (byte0_of(g)),
            .ROM_BYTE1 (byte1_of(g))
        ) dut_u (
            .clk(clk), .rst_b(rst_b), .prog_mode(p_mode), .prog_wr(p_wr),
            .prog_rd(p_rd), .prog_sel(p_sel), .prog_wdata(p_wdata),
            .prog_rdata(rdata_a[g]), .prog_rvalid(rvalid_a[g]), .mem_wipe(wipe_a[g]),
            .halt_req(halt_req), .watchdog_sw_on(watchdog_sw_on),
            .readout_protect(rp_a[g]), .clock_glitch_filter(cgf_a[g]),
            .osc_source_sel(osc_a[g]), .supply_drop_detector(det_a[g]),
            .supply_drop_threshold_sel(thr_a[g]), .irq_vec0_lines(v0_a[g]),
            .irq_vec1_lines(v1_a[g]), .watchdog_enable(we_a[g]),
            .halt_wdg_reset(hwr_a[g]), .halt_enter(hen_a[g])
        );
    end

    prog_tool_model tool_u (
        .clk(clk), .rvalid(rvalid_a[8]), .rdata(rdata_a[8]), .prog_mode(p_mode),
        .prog_wr(p_wr), .prog_rd(p_rd), .prog_sel(p_sel), .prog_wdata(p_wdata)
    );

    always @(posedge clk) begin
        cycles <= cycles + 1;
        for (int k = 0; k < N; k++) begin
            if (wipe_a[k] === 1'b1) wipe_cnt[k] <= wipe_cnt[k] + 1;
        end
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("errors %0d of %0d checks", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        #1;
        rst_b = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // expected decode worked from the byte tables, never from outputs
    task automatic check_dec(input int i, input logic sw);
        logic [7:0] b0, b1;
        logic [6:0] osc;
        logic [2:0] thr;
        b0 = byte0_of(i);
        b1 = byte1_of(i);
        case (b1[6:4])
            3'h7: osc = 7'h40;
            3'h6: osc = 7'h20;
            3'h5, 3'h4: osc = 7'h10;
            default: osc = 7'h01 << b1[6:4];
        endcase
        case (b1[3:2])
            2'h2: thr = 3'h4;
            2'h1: thr = 3'h2;
            2'h0: thr = 3'h1;
            default: thr = 3'h0;
        endcase
        cmp("protect", b0[0], rp_a[i]);
        cmp("filter", !b1[7], cgf_a[i]);
        cmp("osc", osc, osc_a[i]);
        cmp("detector", b1[3:2] != 2'h3, det_a[i]);
        cmp("threshold", thr, thr_a[i]);
        cmp("vec0", b0[1] ? 22'h00_00ff : 22'h3f_00ff, v0_a[i]);
        cmp("vec1", b0[1] ? 22'h3f_ff00 : 22'h00_ff00, v1_a[i]);
        cmp("wdg_en", !b1[0] | sw, we_a[i]);
    endtask

    task automatic read_main(input logic sel, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        tool_u.rd(sel, d, ok);
        cmp("rd_ok", 1'b1, ok);
        cmp("rd_data", exp, d);
        for (int i = 0; i < 8; i++) begin
            cmp("rom_rd", sel ? byte1_of(i) : byte0_of(i), rdata_a[i]);
        end
    endtask

    task automatic t_erased();
        tool_u.set_mode(1'b1);
        for (int i = 0; i < N; i++) check_dec(i, 1'b0);
        read_main(1'b0, 8'hff);
        read_main(1'b1, 8'hff);
    endtask

    task automatic t_outside();
        logic [7:0] d;
        logic ok;
        tool_u.set_mode(1'b0);
        tool_u.wr(1'b1, 8'h00);
        tool_u.rd(1'b1, d, ok);
        cmp("rd_refused", 1'b0, ok);
        tool_u.set_mode(1'b1);
        read_main(1'b1, 8'hff);
    endtask

    task automatic t_write();
        tool_u.wr(1'b1, 8'h5a);
        read_main(1'b1, 8'h5a);
        for (int i = 0; i < N; i++) check_dec(i, 1'b0);
    endtask

    task automatic t_wipe();
        tool_u.wr(1'b0, 8'hfe);
        for (int i = 0; i < N; i++) cmp("wipe", i == 8, wipe_cnt[i]);
        read_main(1'b0, 8'h00);
        read_main(1'b1, 8'h00);
        check_dec(8, 1'b0);
    endtask

    task automatic halt_case(input logic sw);
        logic       on;
        logic [7:0] b1;
        @(posedge clk);
        #1;
        halt_req = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        for (int i = 0; i < N; i++) begin
            b1 = byte1_of(i);
            on = !b1[0] | sw;
            cmp("halt_rst", on & b1[1], hwr_a[i]);
            cmp("halt_enter", !(on & b1[1]), hen_a[i]);
        end
        halt_req = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        for (int i = 0; i < N; i++) cmp("halt_idle", 2'h0, {hwr_a[i], hen_a[i]});
    endtask

    task automatic t_halt();
        halt_case(1'b0);
        watchdog_sw_on = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        watchdog_sw_on = 1'b0;
        for (int i = 0; i < N; i++) check_dec(i, 1'b1);
        halt_case(1'b1);
    endtask

    task automatic t_reset();
        do_reset();
        for (int i = 0; i < N; i++) check_dec(i, 1'b0);
        read_main(1'b0, 8'hff);
    endtask

    initial begin
        for (int k = 0; k < N; k++) wipe_cnt[k] = 0;
        do_reset();
        t_erased();
        t_outside();
        t_write();
        t_wipe();
        t_halt();
        t_reset();
        end_of_test();
    end
endmodule
